// ### dv/gpio_output_write_and_protect_test.sv
// Self-checking bench for the output write mask and protection block
`timescale 1ns/1ps
module gpio_output_write_and_protect_test;
    import gpio_owp_pkg::*;
    logic clk, rst, hsel, hwrite, hready, hreadyout, hresp, protection_on, cfg_wr_stb, irq, rd_pend;
    logic [31:0] haddr, hwdata, hrdata, output_data_value, output_write_mask, cfg_wr_addr, cfg_wr_data;
    logic [31:0] pad_level, m, d, od, v;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [127:0] pad_delay;
    logic [3:0] delay_pad0;
    logic [31:0] exp_q[$];
    logic [31:0] guarded[16];
    int errors, checked;

    assign hready = hreadyout;

    gpio_output_write_and_protect u_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .output_data_value(output_data_value),
        .output_write_mask(output_write_mask), .pad_delay(pad_delay), .protection_on(protection_on),
        .cfg_wr_stb(cfg_wr_stb), .cfg_wr_addr(cfg_wr_addr), .cfg_wr_data(cfg_wr_data), .irq(irq));

    pad_model u_pads (.output_data_value(output_data_value), .pad_delay(pad_delay), .pad_level(pad_level),
        .delay_pad0(delay_pad0));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run;
        $display("Comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run

    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            check({31'h0, hready}, 32'h1);
            complete_run();
        end
    endtask : wait_ready

    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= HSIZE_WORD;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
    endtask : xfer

    task automatic wr(input logic [31:0] a, input logic [31:0] wd);
        xfer(a, 1'b1, wd);
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        xfer(a, 1'b0, 32'h0);
    endtask : rd

    // Read data is compared against the oldest noted expectation
    always @(posedge clk) begin
        if (rst) begin
            rd_pend <= 1'b0;
        end else if (hready === 1'b1) begin
            if (rd_pend && exp_q.size() > 0) begin
                check(hrdata, exp_q.pop_front());
                check({31'h0, hresp}, 32'h0);
            end
            rd_pend <= hsel && htrans === HTRANS_NONSEQ && hwrite === 1'b0;
        end
    end

    initial begin
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = HSIZE_WORD;
        hwdata = 32'h0;
        errors = 0;
        checked = 0;
        od = OUT_DATA_RST;
        m = MASK_RST;
        guarded = '{LINE_EN_ADDR, LINE_DIS_ADDR, OUT_EN_ADDR, OUT_DIS_ADDR, FILT_EN_ADDR, FILT_DIS_ADDR,
            OUT_SET_ADDR, OUT_CLR_ADDR, MDRV_EN_ADDR, MDRV_DIS_ADDR, PULL_DIS_ADDR, PULL_EN_ADDR,
            PERIPH_A_ADDR, PERIPH_B_ADDR, MASK_SET_ADDR, MASK_CLR_ADDR};
        v = $urandom(50417);
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(MASK_STATE_ADDR, MASK_RST);
        rd(PROT_MODE_ADDR, 32'h0);
        rd(PROT_STAT_ADDR, 32'h0);
        rd(MASK_SET_ADDR, 32'h0);
        rd(32'hFFFFF2FC, 32'h0);
        // Direct write with every line masked, then interrupt raise, mask, clear
        d = $urandom | 32'h1;
        wr(OUT_DATA_ADDR, d);
        #1 check(pad_level, od);
        check({31'h0, irq}, 32'h0);
        rd(IRQ_STAT_ADDR, 32'h2);
        wr(IRQ_MASK_ADDR, 32'h3);
        #1 check({31'h0, irq}, 32'h1);
        wr(IRQ_STAT_ADDR, 32'h2);
        #1 check({31'h0, irq}, 32'h0);
        // Random mask set and clear, then direct writes through the mask
        repeat (4) begin
            v = $urandom;
            wr(MASK_SET_ADDR, v);
            m = m | v;
            #1 check(output_write_mask, m);
            check(cfg_wr_addr, MASK_SET_ADDR);
            check(cfg_wr_data, v);
            check({31'h0, cfg_wr_stb}, 32'h1);
            wr(MASK_SET_ADDR, 32'h0);
            rd(MASK_STATE_ADDR, m);
            v = $urandom;
            wr(MASK_CLR_ADDR, v);
            m = m & ~v;
            rd(MASK_STATE_ADDR, m);
            d = $urandom;
            wr(OUT_DATA_ADDR, d);
            od = (od & ~m) | (d & m);
            #1 check(pad_level, od);
        end
        for (int i = 0; i < 4; i++) begin
            v = $urandom;
            wr(DELAY_BASE_ADDR + 32'(4 * i), v);
            if (i == 0) begin
                d = v;
            end
            rd(DELAY_BASE_ADDR + 32'(4 * i), v);
            check(pad_delay[32*i +: 32], v);
        end
        check({28'h0, delay_pad0}, {28'h0, d[3:0]});
        // Wrong key, then right key
        wr(PROT_MODE_ADDR, 32'h534D4301);
        rd(PROT_MODE_ADDR, 32'h0);
        wr(PROT_MODE_ADDR, {PROT_KEY, 8'h01});
        rd(PROT_MODE_ADDR, 32'h1);
        check({31'h0, protection_on}, 32'h1);
        rd(PROT_STAT_ADDR, 32'h0);
        for (int i = 0; i < 16; i++) begin
            wr(guarded[i], 32'hFFFFFFFF);
            #1 check({31'h0, cfg_wr_stb}, 32'h0);
            rd(PROT_STAT_ADDR, {8'h0, guarded[i][15:0], 8'h01});
        end
        rd(MASK_STATE_ADDR, m);
        check(pad_level, od);
        rd(PROT_STAT_ADDR, 32'h0);
        check({31'h0, irq}, 32'h1);
        wr(IRQ_STAT_ADDR, 32'h3);
        #1 check({31'h0, irq}, 32'h0);
        // Unlock and confirm guarded writes work again
        wr(PROT_MODE_ADDR, {PROT_KEY, 8'h00});
        rd(PROT_MODE_ADDR, 32'h0);
        wr(MASK_SET_ADDR, 32'hFFFFFFFF);
        rd(MASK_STATE_ADDR, 32'hFFFFFFFF);
        rd(PROT_STAT_ADDR, 32'h0);
        repeat (3) @(posedge clk);
        check(32'(exp_q.size()), 32'h0);
        complete_run();
    end
endmodule : gpio_output_write_and_protect_test

// ### dv/pad_model.sv
// Pad side model: each line shows the level driven by the block
`timescale 1ns/1ps
module pad_model (
    input wire logic [31:0] output_data_value,
    input wire logic [127:0] pad_delay,
    output logic [31:0] pad_level,
    output logic [3:0] delay_pad0
);
    assign pad_level = output_data_value;
    assign delay_pad0 = pad_delay[3:0];
endmodule : pad_model

// ### rtl/gpio_output_write_and_protect.sv
// Output write mask, pad delays and keyed write protection behind AHB-Lite
//
// Summary of operation
// - Set register ones enable direct output writes
// - Clear register ones mask direct output writes
// - State register reads one where writes pass
// - Four read/write registers of eight delay fields
// - Protection bit changes only with matching key
// - Wrong key aborts protection bit update
// - Key field always reads zero
// - Protection guards the listed configuration registers
// - Violation flag set, zero after read
// - Violation source records first offending register offset
// - Status read clears flag and source
`timescale 1ns/1ps
module gpio_output_write_and_protect
    import gpio_owp_pkg::*;
#(
    parameter int N_LINES = gpio_owp_pkg::LINES,
    parameter int N_DELAY = gpio_owp_pkg::DELAY_REGS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic [N_LINES-1:0] output_data_value,
    output logic [N_LINES-1:0] output_write_mask,
    output logic [32*N_DELAY-1:0] pad_delay,
    output logic protection_on,
    output logic cfg_wr_stb,
    output logic [31:0] cfg_wr_addr,
    output logic [31:0] cfg_wr_data,
    output logic irq
);
    import gpio_owp_pkg::*;

    function automatic logic is_guarded(input logic [31:0] a);
        is_guarded = (a == LINE_EN_ADDR) || (a == LINE_DIS_ADDR) || (a == OUT_EN_ADDR) ||
            (a == OUT_DIS_ADDR) || (a == FILT_EN_ADDR) || (a == FILT_DIS_ADDR) ||
            (a == OUT_SET_ADDR) || (a == OUT_CLR_ADDR) || (a == MDRV_EN_ADDR) ||
            (a == MDRV_DIS_ADDR) || (a == PULL_DIS_ADDR) || (a == PULL_EN_ADDR) ||
            (a == PERIPH_A_ADDR) || (a == PERIPH_B_ADDR) || (a == MASK_SET_ADDR) ||
            (a == MASK_CLR_ADDR);
    endfunction : is_guarded

    function automatic logic is_delay(input logic [31:0] a, input int idx);
        is_delay = (a == DELAY_BASE_ADDR + 32'(4 * idx));
    endfunction : is_delay

    dp_state_t dp_state_q, dp_state_d;
    logic [31:0] dp_addr_q;
    logic [31:0] hrdata_q;
    logic [N_LINES-1:0] mask_q, mask_d;
    logic [N_LINES-1:0] out_q, out_d;
    logic [31:0] delay_q [N_DELAY];
    logic prot_q, prot_d;
    logic vflag_q, vflag_d;
    logic [VSRC_W-1:0] vsrc_q, vsrc_d;
    logic cfg_stb_q;
    logic [31:0] cfg_addr_q, cfg_data_q;
    logic [EVENTS-1:0] irq_mask_q;
    logic [EVENTS-1:0] irq_flags;

    // Bus decode
    wire logic accept = hsel && hready && (htrans == HTRANS_NONSEQ) && (hsize == HSIZE_WORD);
    wire logic wr_fire = (dp_state_q == DP_WRITE);
    wire logic rd_cap = (dp_state_q == DP_READ);
    wire logic wr_guarded = wr_fire && is_guarded(dp_addr_q);
    wire logic wr_blocked = wr_guarded && prot_q;
    wire logic wr_ok = wr_fire && !wr_blocked;
    wire logic wr_mask_set = wr_ok && (dp_addr_q == MASK_SET_ADDR);
    wire logic wr_mask_clr = wr_ok && (dp_addr_q == MASK_CLR_ADDR);
    wire logic wr_out_set = wr_ok && (dp_addr_q == OUT_SET_ADDR);
    wire logic wr_out_clr = wr_ok && (dp_addr_q == OUT_CLR_ADDR);
    wire logic wr_out_data = wr_fire && (dp_addr_q == OUT_DATA_ADDR);
    wire logic wr_prot = wr_fire && (dp_addr_q == PROT_MODE_ADDR);
    wire logic key_match = (hwdata[KEY_LSB +: KEY_W] == PROT_KEY);
    wire logic rd_vstat = rd_cap && (dp_addr_q == PROT_STAT_ADDR);
    wire logic wr_irq_stat = wr_fire && (dp_addr_q == IRQ_STAT_ADDR);
    wire logic wr_irq_mask = wr_fire && (dp_addr_q == IRQ_MASK_ADDR);
    wire logic masked_touch = wr_out_data && (|((hwdata ^ out_q) & ~mask_q));

    always_comb begin
        dp_state_d = DP_IDLE;
        case (dp_state_q)
            DP_IDLE, DP_WRITE: begin
                if (accept) begin
                    dp_state_d = hwrite ? DP_WRITE : DP_READ;
                end
            end
            DP_READ: dp_state_d = DP_IDLE;
            default: dp_state_d = DP_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dp_state_q <= DP_IDLE;
            dp_addr_q <= 32'h00000000;
        end else begin
            dp_state_q <= dp_state_d;
            if (accept) begin
                dp_addr_q <= haddr;
            end
        end
    end

    // Output write mask
    always_comb begin
        mask_d = mask_q;
        if (wr_mask_set) begin
            mask_d = mask_q | hwdata[N_LINES-1:0];
        end else if (wr_mask_clr) begin
            mask_d = mask_q & ~hwdata[N_LINES-1:0];
        end
    end

    // Output data value
    always_comb begin
        out_d = out_q;
        if (wr_out_set) begin
            out_d = out_q | hwdata[N_LINES-1:0];
        end else if (wr_out_clr) begin
            out_d = out_q & ~hwdata[N_LINES-1:0];
        end else if (wr_out_data) begin
            out_d = (out_q & ~mask_q) | (hwdata[N_LINES-1:0] & mask_q);
        end
    end

    // Protection enable
    always_comb begin
        prot_d = prot_q;
        if (wr_prot && key_match) begin
            prot_d = hwdata[PROT_ON_BIT];
        end
    end

    // Violation recording, set wins over read clear
    always_comb begin
        vflag_d = vflag_q;
        vsrc_d = vsrc_q;
        if (rd_vstat) begin
            vflag_d = 1'b0;
            vsrc_d = '0;
        end
        if (wr_blocked) begin
            vflag_d = 1'b1;
            if (!vflag_q || rd_vstat) begin
                vsrc_d = dp_addr_q[VSRC_W-1:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mask_q <= MASK_RST[N_LINES-1:0];
            out_q <= OUT_DATA_RST[N_LINES-1:0];
            prot_q <= PROT_RST;
            vflag_q <= 1'b0;
            vsrc_q <= '0;
        end else begin
            mask_q <= mask_d;
            out_q <= out_d;
            prot_q <= prot_d;
            vflag_q <= vflag_d;
            vsrc_q <= vsrc_d;
        end
    end

    // Pad delay registers
    for (genvar i = 0; i < N_DELAY; i++) begin : g_delay
        always_ff @(posedge clk) begin
            if (rst) begin
                delay_q[i] <= DELAY_RST;
            end else if (wr_fire && is_delay(dp_addr_q, i)) begin
                delay_q[i] <= hwdata;
            end
        end
        assign pad_delay[32*i +: 32] = delay_q[i];
    end

    // Accepted guarded writes passed to the owning logic
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_stb_q <= 1'b0;
            cfg_addr_q <= 32'h00000000;
            cfg_data_q <= 32'h00000000;
        end else begin
            cfg_stb_q <= wr_guarded && !prot_q;
            if (wr_guarded && !prot_q) begin
                cfg_addr_q <= dp_addr_q;
                cfg_data_q <= hwdata;
            end
        end
    end

    // Interrupt flags and mask
    sticky_event_bits #(.W(EVENTS)) u_events (
        .clk(clk),
        .rst(rst),
        .set_bits({masked_touch, wr_blocked}),
        .clear_bits(wr_irq_stat ? hwdata[EVENTS-1:0] : {EVENTS{1'b0}}),
        .flags(irq_flags)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_mask_q <= '0;
        end else if (wr_irq_mask) begin
            irq_mask_q <= hwdata[EVENTS-1:0];
        end
    end

    // Read data
    logic [31:0] delay_rd;
    always_comb begin
        delay_rd = 32'h00000000;
        for (int i = 0; i < N_DELAY; i++) begin
            if (is_delay(dp_addr_q, i)) begin
                delay_rd = delay_q[i];
            end
        end
    end

    wire logic [31:0] rd_mux =
        (dp_addr_q == MASK_STATE_ADDR) ? 32'(mask_q) :
        (dp_addr_q == OUT_DATA_ADDR) ? 32'(out_q) :
        (dp_addr_q == PROT_MODE_ADDR) ? {31'h00000000, prot_q} :
        (dp_addr_q == PROT_STAT_ADDR) ? {8'h00, vsrc_q, 7'h00, vflag_q} :
        (dp_addr_q == IRQ_STAT_ADDR) ? 32'(irq_flags) :
        (dp_addr_q == IRQ_MASK_ADDR) ? 32'(irq_mask_q) :
        delay_rd;

    always_ff @(posedge clk) begin
        if (rst) begin
            hrdata_q <= 32'h00000000;
        end else if (rd_cap) begin
            hrdata_q <= rd_mux;
        end
    end

    assign hreadyout = (dp_state_q != DP_READ);
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign output_data_value = out_q;
    assign output_write_mask = mask_q;
    assign protection_on = prot_q;
    assign cfg_wr_stb = cfg_stb_q;
    assign cfg_wr_addr = cfg_addr_q;
    assign cfg_wr_data = cfg_data_q;
    assign irq = |(irq_flags & irq_mask_q);

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_mask_set_bits: assert property (wr_fire && !prot_q && dp_addr_q == MASK_SET_ADDR
        |=> (mask_q & $past(hwdata[N_LINES-1:0])) == $past(hwdata[N_LINES-1:0]))
        else $error("mask set did not enable lines");
    a_mask_clear_bits: assert property (wr_fire && !prot_q && dp_addr_q == MASK_CLR_ADDR
        |=> (mask_q & $past(hwdata[N_LINES-1:0])) == '0 &&
        ((mask_q ^ $past(mask_q)) & ~$past(hwdata[N_LINES-1:0])) == '0)
        else $error("mask clear wrong");
    a_mask_zero_keep: assert property (wr_fire && dp_addr_q == MASK_SET_ADDR
        |=> ((mask_q ^ $past(mask_q)) & ~$past(hwdata[N_LINES-1:0])) == '0)
        else $error("mask set zero bit changed line");
    a_masked_data_keep: assert property (wr_fire && dp_addr_q == OUT_DATA_ADDR
        |=> ((out_q ^ $past(out_q)) & ~$past(mask_q)) == '0 &&
        ((out_q ^ $past(hwdata[N_LINES-1:0])) & $past(mask_q)) == '0)
        else $error("direct output write ignored mask");
    a_state_readback: assert property (rd_cap && dp_addr_q == MASK_STATE_ADDR
        |=> hrdata == 32'($past(mask_q)) && hreadyout)
        else $error("mask state read wrong");
    a_delay_store: assert property (wr_fire && dp_addr_q == DELAY_BASE_ADDR
        |=> pad_delay[31:0] == $past(hwdata))
        else $error("delay register not stored");
    a_key_guard: assert property (wr_fire && dp_addr_q == PROT_MODE_ADDR
        && hwdata[KEY_LSB +: KEY_W] != PROT_KEY |=> $stable(protection_on))
        else $error("bad key changed protection");
    a_key_accept: assert property (wr_fire && dp_addr_q == PROT_MODE_ADDR && key_match
        |=> protection_on == $past(hwdata[PROT_ON_BIT]))
        else $error("good key did not update protection");
    a_key_reads_zero: assert property (rd_cap && dp_addr_q == PROT_MODE_ADDR
        |=> hrdata[31:KEY_LSB] == '0)
        else $error("key field read nonzero");
    a_guard_block: assert property (wr_fire && prot_q && is_guarded(dp_addr_q)
        |=> !cfg_wr_stb && $stable(mask_q) && $stable(out_q) && vflag_q)
        else $error("guarded write not blocked");
    a_violation_src: assert property (wr_blocked && !vflag_q
        |=> vsrc_q == $past(dp_addr_q[VSRC_W-1:0]))
        else $error("violation source wrong");
    a_read_clears: assert property (rd_vstat && !wr_blocked
        |=> !vflag_q && vsrc_q == '0 ##1 (hrdata[VFLAG_BIT] == $past(vflag_q, 2)))
        else $error("status read did not clear");
    a_read_wait: assert property (accept && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");

    c_protected_violation: cover property (wr_blocked ##[1:20] rd_vstat);
    c_masked_write: cover property (wr_mask_clr ##[1:20] wr_out_data);
    c_unlock: cover property (wr_prot && key_match && !hwdata[PROT_ON_BIT] && prot_q);
    c_irq: cover property (irq);
endmodule : gpio_output_write_and_protect

// ### rtl/gpio_owp_pkg.sv
// Constants for the output write mask and write protection block
package gpio_owp_pkg;
    localparam int LINES = 32;
    localparam int DELAY_REGS = 4;
    localparam int DELAY_FIELD_W = 4;
    localparam int VSRC_W = 16;
    localparam int EVENTS = 2;

    // Register byte addresses
    localparam logic [31:0] LINE_EN_ADDR = 32'hFFFFF200;
    localparam logic [31:0] LINE_DIS_ADDR = 32'hFFFFF204;
    localparam logic [31:0] OUT_EN_ADDR = 32'hFFFFF210;
    localparam logic [31:0] OUT_DIS_ADDR = 32'hFFFFF214;
    localparam logic [31:0] FILT_EN_ADDR = 32'hFFFFF220;
    localparam logic [31:0] FILT_DIS_ADDR = 32'hFFFFF224;
    localparam logic [31:0] OUT_SET_ADDR = 32'hFFFFF230;
    localparam logic [31:0] OUT_CLR_ADDR = 32'hFFFFF234;
    localparam logic [31:0] OUT_DATA_ADDR = 32'hFFFFF238;
    localparam logic [31:0] MDRV_EN_ADDR = 32'hFFFFF250;
    localparam logic [31:0] MDRV_DIS_ADDR = 32'hFFFFF254;
    localparam logic [31:0] PULL_DIS_ADDR = 32'hFFFFF260;
    localparam logic [31:0] PULL_EN_ADDR = 32'hFFFFF264;
    localparam logic [31:0] PERIPH_A_ADDR = 32'hFFFFF270;
    localparam logic [31:0] PERIPH_B_ADDR = 32'hFFFFF274;
    localparam logic [31:0] MASK_SET_ADDR = 32'hFFFFF2A0;
    localparam logic [31:0] MASK_CLR_ADDR = 32'hFFFFF2A4;
    localparam logic [31:0] MASK_STATE_ADDR = 32'hFFFFF2A8;
    localparam logic [31:0] DELAY_BASE_ADDR = 32'hFFFFF2C0;
    localparam logic [31:0] PROT_MODE_ADDR = 32'hFFFFF2E4;
    localparam logic [31:0] PROT_STAT_ADDR = 32'hFFFFF2E8;
    localparam logic [31:0] IRQ_STAT_ADDR = 32'hFFFFF2F0;
    localparam logic [31:0] IRQ_MASK_ADDR = 32'hFFFFF2F4;

    // Field positions and values
    localparam int PROT_ON_BIT = 0;
    localparam int KEY_LSB = 8;
    localparam int KEY_W = 24;
    localparam logic [23:0] PROT_KEY = 24'h50494F;
    localparam int VFLAG_BIT = 0;
    localparam int VSRC_LSB = 8;
    localparam int EV_VIOLATION = 0;
    localparam int EV_MASKED_WRITE = 1;

    // Reset values
    localparam logic [31:0] MASK_RST = 32'h00000000;
    localparam logic [31:0] OUT_DATA_RST = 32'h00000000;
    localparam logic [31:0] DELAY_RST = 32'h00000000;
    localparam logic PROT_RST = 1'b0;

    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [2:0] HSIZE_WORD = 3'b010;

    typedef enum logic [1:0] {DP_IDLE, DP_WRITE, DP_READ} dp_state_t;
endpackage : gpio_owp_pkg

// ### rtl/sticky_event_bits.sv
// Sticky event flags, set has priority over clear
`timescale 1ns/1ps
module sticky_event_bits #(
    parameter int W = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] set_bits,
    input wire logic [W-1:0] clear_bits,
    output logic [W-1:0] flags
);
    logic [W-1:0] flags_q;

    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk) begin
            if (rst) begin
                flags_q[i] <= 1'b0;
            end else if (set_bits[i]) begin
                flags_q[i] <= 1'b1;
            end else if (clear_bits[i]) begin
                flags_q[i] <= 1'b0;
            end
        end
    end

    assign flags = flags_q;
endmodule : sticky_event_bits
